// ===== adcc_params.svh
// Constants for the converter control block: widths, counts, encodings.
// Assumes nothing beyond a SystemVerilog compiler with macro support.
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH

`define ADCC_RES_BITS      12
`define ADCC_CHAN_BITS     4
`define ADCC_NUM_CHAN      14
`define ADCC_ACQ_CYCLES    8
`define ADCC_FMT_RIGHT     1'b1
`define ADCC_REF_INTERNAL  1'b0
`define ADCC_REF_EXTERNAL  1'b1

`endif

// ===== adcc_pkg.sv
// Types shared by the converter control block.
// Assumes adcc_params.svh is on the include path.
`include "adcc_params.svh"

package adcc_pkg;

   typedef enum logic [1:0] {
      ADCC_IDLE,
      ADCC_ACQ,
      ADCC_CONV,
      ADCC_STORE
   } adcc_state_type;

   typedef struct packed {
      logic [`ADCC_CHAN_BITS-1:0] pos_chan;
      logic [`ADCC_CHAN_BITS-1:0] neg_chan;
      logic                       differential;
      logic                       ref_sel;
      logic                       right_justify;
   } adcc_cfg_type;

   typedef struct packed {
      logic [7:0] result_high_byte;
      logic [7:0] result_low_byte;
   } adcc_result_type;

endpackage

// ===== adcc_sar.sv
// Successive-approximation register for the converter core.
// Assumes the analog comparator answers within one clock of the trial code.
`timescale 1ns/1ps
`include "adcc_params.svh"

module adcc_sar #(
   parameter int WIDTH = `ADCC_RES_BITS
) (
   input  wire logic             i_clk,
   input  wire logic             i_rstn,
   input  wire logic             i_start,
   input  wire logic             i_cmp_high,
   output logic [WIDTH-1:0]      o_trial,
   output logic [WIDTH-1:0]      o_code,
   output logic                  o_done
);

   logic [WIDTH-1:0] trial;
   logic [WIDTH-1:0] bit_mask;
   logic             done;
   logic [WIDTH-1:0] next_trial;
   logic [WIDTH-1:0] next_bit_mask;
   logic             next_done;

   // One bit resolved per step, MSB first
   always_comb begin
      next_trial    = trial;
      next_bit_mask = bit_mask;
      next_done     = 1'b0;
      if (i_start) begin
         next_bit_mask = {1'b1, {(WIDTH-1){1'b0}}};
         next_trial    = {1'b1, {(WIDTH-1){1'b0}}};
      end else if (bit_mask != '0) begin
         if (i_cmp_high) begin
            next_trial = trial & ~bit_mask;
         end
         next_bit_mask = bit_mask >> 1;
         next_trial    = next_trial | (bit_mask >> 1);
         next_done     = (bit_mask[0] == 1'b1);
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         trial    <= '0;
         bit_mask <= '0;
         done     <= 1'b0;
      end else begin
         trial    <= next_trial;
         bit_mask <= next_bit_mask;
         done     <= next_done;
      end
   end

   assign o_trial = trial;
   assign o_code  = trial;
   assign o_done  = done;

   AST_SAR_STEPS: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_start |=> !done [*8] ##1 !done [*4] ##1 done)
      else $error("Conversion did not finish in twelve steps");

endmodule // adcc_sar

// ===== adcc_ctrl.sv
// Conversion control: channel mux select, sample/hold, SAR sequencing,
// result pair, completion flag and wake request. No software bus.
// Assumes an analog front end driven by o_mux_* and o_sample_hold and a
// comparator on i_cmp_high that reports input below the trial code.
`timescale 1ns/1ps
`include "adcc_params.svh"

module adcc_ctrl #(
   parameter int ACQ_CYCLES = `ADCC_ACQ_CYCLES
) (
   input  wire logic                       i_clk,
   input  wire logic                       i_rstn,
   input  wire logic                       i_start,
   input  wire adcc_pkg::adcc_cfg_type     i_cfg,
   input  wire logic                       i_cmp_high,
   input  wire logic                       i_flag_clear,
   input  wire logic                       i_irq_enable,
   input  wire logic                       i_global_irq_enable,
   input  wire logic                       i_sleeping,
   output logic [`ADCC_CHAN_BITS-1:0]      o_mux_pos,
   output logic [`ADCC_CHAN_BITS-1:0]      o_mux_neg,
   output logic                            o_mux_diff,
   output logic                            o_ref_external,
   output logic                            o_sample_hold,
   output logic [`ADCC_RES_BITS-1:0]       o_dac_code,
   output logic                            o_busy,
   output adcc_pkg::adcc_result_type       o_result,
   output logic                            o_conversion_done_flag,
   output logic                            o_irq,
   output logic                            o_wake
);

   adcc_pkg::adcc_state_type   state;
   adcc_pkg::adcc_state_type   next_state;
   adcc_pkg::adcc_cfg_type     cfg;
   adcc_pkg::adcc_cfg_type     next_cfg;
   adcc_pkg::adcc_result_type  result;
   adcc_pkg::adcc_result_type  next_result;
   logic [7:0]                 acq_cnt;
   logic [7:0]                 next_acq_cnt;
   logic                       flag;
   logic                       next_flag;
   logic                       sar_start;
   logic [`ADCC_RES_BITS-1:0]  sar_code;
   logic                       sar_done;
   logic [8:0]                 hold_len;
   logic [8:0]                 next_hold_len;

   // Formats the 12-bit code into the result byte pair
   function automatic adcc_pkg::adcc_result_type pack_result(
      input logic [`ADCC_RES_BITS-1:0] code,
      input logic                      right
   );
      adcc_pkg::adcc_result_type r;
      if (right) begin
         r.result_high_byte = {4'h0, code[11:8]};
         r.result_low_byte  = code[7:0];
      end else begin
         r.result_high_byte = code[11:4];
         r.result_low_byte  = {code[3:0], 4'h0};
      end
      return r;
   endfunction

   adcc_sar #(
      .WIDTH (`ADCC_RES_BITS)
   ) u_sar (
      .i_clk      (i_clk),
      .i_rstn     (i_rstn),
      .i_start    (sar_start),
      .i_cmp_high (i_cmp_high),
      .o_trial    (o_dac_code),
      .o_code     (sar_code),
      .o_done     (sar_done)
   );

   always_comb begin
      next_state   = state;
      next_cfg     = cfg;
      next_result  = result;
      next_acq_cnt = acq_cnt;
      sar_start    = 1'b0;
      unique case (state)
         adcc_pkg::ADCC_IDLE: begin
            if (i_start) begin
               // Config frozen for the whole conversion so the mux can't move mid-sample
               next_cfg     = i_cfg;
               next_acq_cnt = 8'(ACQ_CYCLES - 1);
               next_state   = adcc_pkg::ADCC_ACQ;
            end
         end
         adcc_pkg::ADCC_ACQ: begin
            if (acq_cnt == 8'h00) begin
               sar_start  = 1'b1;
               next_state = adcc_pkg::ADCC_CONV;
            end else begin
               next_acq_cnt = acq_cnt - 8'h01;
            end
         end
         adcc_pkg::ADCC_CONV: begin
            if (sar_done) begin
               next_state = adcc_pkg::ADCC_STORE;
            end
         end
         adcc_pkg::ADCC_STORE: begin
            next_result = pack_result(sar_code, cfg.right_justify);
            next_state  = adcc_pkg::ADCC_IDLE;
         end
      endcase
   end

   // Set wins over a simultaneous software clear
   always_comb begin
      next_flag = flag;
      if (i_flag_clear) begin
         next_flag = 1'b0;
      end
      if (state == adcc_pkg::ADCC_STORE) begin
         next_flag = 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state   <= adcc_pkg::ADCC_IDLE;
         cfg     <= '0;
         result  <= '0;
         acq_cnt <= 8'h00;
         flag    <= 1'b0;
      end else begin
         state   <= next_state;
         cfg     <= next_cfg;
         result  <= next_result;
         acq_cnt <= next_acq_cnt;
         flag    <= next_flag;
      end
   end

   assign o_mux_pos              = cfg.pos_chan;
   assign o_mux_neg              = cfg.neg_chan;
   assign o_mux_diff             = cfg.differential;
   assign o_ref_external         = cfg.ref_sel;
   assign o_sample_hold          = (state == adcc_pkg::ADCC_ACQ);
   assign o_busy                 = (state != adcc_pkg::ADCC_IDLE);
   assign o_result               = result;
   assign o_conversion_done_flag = flag;
   assign o_irq                  = flag & i_irq_enable & i_global_irq_enable;
   // Wake ignores the global enable, by design
   assign o_wake                 = flag & i_irq_enable & i_sleeping;

   // Helper count of acquisition cycles, only read by the window check
   always_comb begin
      next_hold_len = o_sample_hold ? hold_len + 9'h001 : 9'h000;
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         hold_len <= 9'h000;
      end else begin
         hold_len <= next_hold_len;
      end
   end

   sequence seq_store;
      state == adcc_pkg::ADCC_STORE;
   endsequence

   sequence seq_flag_up;
      flag && $changed(result) || flag;
   endsequence

   AST_FLAG_ON_STORE: assert property (@(posedge i_clk) disable iff (!i_rstn)
      seq_store |=> seq_flag_up)
      else $error("Done flag not set after result update");

   AST_FLAG_HOLDS: assert property (@(posedge i_clk) disable iff (!i_rstn)
      flag && !i_flag_clear |=> flag)
      else $error("Done flag dropped without clear");

   AST_RESULT_PAIR: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (seq_store and cfg.right_justify) |=> result.result_high_byte[7:4] == 4'h0
         && {result.result_high_byte[3:0], result.result_low_byte} == $past(sar_code))
      else $error("Result pair does not match converted code");

   AST_CONV_TIME: assert property (@(posedge i_clk) disable iff (!i_rstn)
      state == adcc_pkg::ADCC_IDLE && i_start |-> ##[14:300] seq_store)
      else $error("Conversion did not complete in time");

   AST_IRQ: assert property (@(posedge i_clk) disable iff (!i_rstn)
      o_irq |-> flag && i_irq_enable && i_global_irq_enable)
      else $error("Interrupt without flag and enables");

   AST_WAKE_NO_GIE: assert property (@(posedge i_clk) disable iff (!i_rstn)
      flag && i_irq_enable && i_sleeping && !i_global_irq_enable |-> o_wake)
      else $error("Wake missed with global interrupts off");

   AST_WAKE_ONLY_ENABLED: assert property (@(posedge i_clk) disable iff (!i_rstn)
      o_wake |-> i_irq_enable && flag)
      else $error("Wake without enabled flag");

   AST_MUX_STABLE: assert property (@(posedge i_clk) disable iff (!i_rstn)
      o_busy && $past(o_busy) |-> $stable(o_mux_pos) && $stable(o_mux_diff) && $stable(o_ref_external))
      else $error("Input selection changed during conversion");

   AST_RESULT_LEFT: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (seq_store and !cfg.right_justify) |=> result.result_low_byte[3:0] == 4'h0
         && {result.result_high_byte, result.result_low_byte[7:4]} == $past(sar_code))
      else $error("Left-justified result pair does not match converted code");

   // Short sampling would leave the hold capacitor unsettled
   AST_ACQ_WINDOW: assert property (@(posedge i_clk) disable iff (!i_rstn)
      $fell(o_sample_hold) |-> hold_len == 9'(ACQ_CYCLES))
      else $error("Acquisition window length wrong");

   sequence seq_conv_end;
      state == adcc_pkg::ADCC_CONV && sar_done;
   endsequence

   AST_STORE_STEP: assert property (@(posedge i_clk) disable iff (!i_rstn)
      seq_conv_end |=> seq_store ##1 !o_busy)
      else $error("Store step out of order");

endmodule // adcc_ctrl

// ===== tb_adc_conversion_control.sv
// Self-checking bench for the converter control block.
// Assumes adcc_params.svh and adcc_pkg are compiled ahead of this file.
`timescale 1ns/1ps
`include "adcc_params.svh"

module tb_adc_conversion_control;
   logic                      i_clk = 1'b0;
   logic                      i_rstn = 1'b0;
   logic                      i_start = 1'b0;
   logic                      i_flag_clear = 1'b0;
   logic                      i_irq_enable = 1'b0;
   logic                      i_global_irq_enable = 1'b0;
   logic                      i_sleeping = 1'b0;
   adcc_pkg::adcc_cfg_type    i_cfg = '0;
   logic [11:0]               vin = '0;
   logic                      i_cmp_high;
   logic [3:0]                o_mux_pos, o_mux_neg;
   logic                      o_mux_diff, o_ref_external, o_sample_hold, o_busy;
   logic                      o_conversion_done_flag, o_irq, o_wake;
   logic [11:0]               o_dac_code;
   adcc_pkg::adcc_result_type o_result;
   int                        err_count = 0;
   int                        checked = 0;
   logic [15:0]               exp_q[$];
   logic                      prev_busy = 1'b0;
   int                        hold_n = 0;
   int                        busy_n = 0;

   // Ideal comparator: input below trial code clears the trial bit
   assign i_cmp_high = (vin < o_dac_code);

   always #50 i_clk = ~i_clk;

   adcc_ctrl i_adcc_ctrl (.i_clk(i_clk), .i_rstn(i_rstn), .i_start(i_start), .i_cfg(i_cfg),
      .i_cmp_high(i_cmp_high), .i_flag_clear(i_flag_clear), .i_irq_enable(i_irq_enable),
      .i_global_irq_enable(i_global_irq_enable), .i_sleeping(i_sleeping), .o_mux_pos(o_mux_pos),
      .o_mux_neg(o_mux_neg), .o_mux_diff(o_mux_diff), .o_ref_external(o_ref_external),
      .o_sample_hold(o_sample_hold), .o_dac_code(o_dac_code), .o_busy(o_busy), .o_result(o_result),
      .o_conversion_done_flag(o_conversion_done_flag), .o_irq(o_irq), .o_wake(o_wake));

   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task finish_test;
      $display("Counts: %0d checked, %0d mismatches", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Result watcher: one note taken off per completed conversion
   always @(negedge i_clk) begin
      hold_n += int'(o_sample_hold);
      busy_n += int'(o_busy);
      if (prev_busy && !o_busy) begin
         if (exp_q.size() == 0)
            chk("spare result", 16'h0, 16'h1);
         else
            chk("result", exp_q.pop_front(), o_result);
         chk("done flag", 16'h1, 16'(o_conversion_done_flag));
         chk("hold cycles", 16'(`ADCC_ACQ_CYCLES), 16'(hold_n));
         chk("busy cycles", 16'(`ADCC_ACQ_CYCLES + `ADCC_RES_BITS + 2), 16'(busy_n));
         hold_n = 0;
         busy_n = 0;
      end
      prev_busy = o_busy;
   end

   task conv(input logic [11:0] v, input logic clr);
      adcc_pkg::adcc_cfg_type c;
      int                     n;
      c = '{pos_chan: 4'($urandom_range(13)), neg_chan: 4'($urandom_range(13)),
            differential: 1'($urandom), ref_sel: 1'($urandom), right_justify: 1'($urandom)};
      @(posedge i_clk);
      i_cfg <= c;
      vin <= v;
      i_start <= 1'b1;
      // Clear taken with the start, so completion must set the flag afresh
      i_flag_clear <= 1'b1;
      exp_q.push_back(c.right_justify ? {4'h0, v} : {v, 4'h0});
      @(posedge i_clk);
      i_start <= 1'b0;
      i_flag_clear <= clr;
      @(negedge i_clk);
      chk("busy hold flag", 16'h6, {13'h0, o_busy, o_sample_hold, o_conversion_done_flag});
      chk("mux", {6'h0, c[10:1]}, {6'h0, o_mux_pos, o_mux_neg, o_mux_diff, o_ref_external});
      // Start while busy must be dropped, not queued
      @(posedge i_clk);
      i_start <= 1'b1;
      i_cfg <= ~c;
      @(posedge i_clk);
      i_start <= 1'b0;
      i_cfg <= c;
      @(negedge i_clk);
      chk("mux kept", {6'h0, c[10:1]}, {6'h0, o_mux_pos, o_mux_neg, o_mux_diff, o_ref_external});
      n = 0;
      while (o_busy && n < 300) begin
         @(negedge i_clk);
         n++;
      end
      if (o_busy) begin
         chk("conversion timeout", 16'h0, 16'h1);
         finish_test;
      end
      @(posedge i_clk);
      i_flag_clear <= 1'b0;
   endtask

   initial begin
      void'($urandom(41799));
      repeat (19) @(posedge i_clk);
      @(negedge i_clk);
      chk("reset outputs", 16'h0, {12'h0, o_busy, o_conversion_done_flag, o_irq, o_wake});
      @(posedge i_clk);
      i_rstn <= 1'b1;
      // Third run holds the clear high: set must win at completion
      for (int i = 0; i < 10; i++)
         conv(i == 0 ? 12'h000 : i == 1 ? 12'hfff : 12'($urandom_range(4095)), i == 2);
      chk("notes left", 16'h0, 16'(exp_q.size()));
      $display("Test conversions done");
      for (int k = 0; k < 8; k++) begin
         @(posedge i_clk);
         {i_irq_enable, i_global_irq_enable, i_sleeping} <= 3'(k);
         @(negedge i_clk);
         chk("irq wake", {14'h0, k[2] & k[1], k[2] & k[0]}, {14'h0, o_irq, o_wake});
      end
      $display("Test interrupt and wake done");
      @(posedge i_clk);
      i_flag_clear <= 1'b1;
      @(posedge i_clk);
      i_flag_clear <= 1'b0;
      @(negedge i_clk);
      chk("cleared", 16'h0, {13'h0, o_conversion_done_flag, o_irq, o_wake});
      $display("Test flag clear done");
      finish_test;
   end
endmodule // tb_adc_conversion_control
